// [pkg/gpf_pkg.sv]
package gpf_pkg;
   // =====================================================================
   // register offsets (byte addresses)
   // =====================================================================
   localparam logic [7:0] OFS_PIN_DATA      = 8'h00;
   localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h04;
   localparam logic [7:0] OFS_FUNCTION_SEL  = 8'h08;
   localparam logic [7:0] OFS_RESERVED      = 8'h0C;
   localparam logic [7:0] OFS_OPEN_DRAIN    = 8'h28;
   localparam logic [7:0] OFS_PULLUP        = 8'h2C;
   localparam logic [7:0] OFS_INPUT_ENABLE  = 8'h38;
   localparam logic [7:0] OFS_STOP_CTRL     = 8'h3C;
   // =====================================================================
   // field layout and reset values
   // =====================================================================
   localparam int         PORT_LSB    = 4;
   localparam int         PORT_WIDTH  = 3;
   localparam int         STOP_DRV_POS = 0;
   localparam int         STOP_ACT_POS = 1;
   localparam logic [2:0] RST_FIELD   = 3'h0;
   localparam logic [1:0] RST_STOP    = 2'h0;
   localparam logic [7:0] ADDR_MASK   = 8'hFC;
endpackage

// [core/gpf_sync.sv]
`timescale 1ns/1ps
// =====================================================================
// three-stage synchroniser; output changes once stages two and three agree
// =====================================================================
module gpf_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk_i,   // system clock
   input  wire logic             rst_i,   // sync reset, active high
   input  wire logic [WIDTH-1:0] d_i,     // asynchronous level
   output logic      [WIDTH-1:0] q_o      // filtered level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } gpf_sync_st_t;

   gpf_sync_st_t st;
   gpf_sync_st_t next_st;

   if (WIDTH < 1) begin : g_bad_width
      $error("gpf_sync width must be at least one");
   end

   always_comb begin
      next_st    = st;
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         // s1 is not read here; only s2 and s3 vote
         if (st.s2[i] == st.s3[i]) begin
            next_st.q[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.q;
endmodule // gpf_sync

// [core/gpf_port.sv]
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - three pins at bits 6..4, each separately input or output
// - reset: port function selected; driver, input buffer and pull-up all off
// - function select 0 gives port logic, 1 gives serial channel
// - alternate function plus input enable keeps wake input alive in stop
// - outside stop, wake input passes when input enable set, any function
// - data at 0x00, output enable at 0x04, function select at 0x08
// - open drain at 0x28, pull-up at 0x2C, input enable at 0x38
// - data bits 6..4: writes feed outputs, reads return pin state
// - output enable bit 0 disables driver, 1 enables it
// - alternate: bit6 serial clock, bit5 serial in/scl, bit4 out/sda
// - open drain bit 0 push-pull, 1 open drain
// - pull-up bit 0 off, 1 on
// - input enable bit 0 blocks input buffer, 1 passes pin level
module gpf_port (
   input  wire logic        clk_i,        // system clock, 125 MHz
   input  wire logic        rst_i,        // sync reset, active high
   input  wire logic        wb_cyc_i,     // wishbone cycle
   input  wire logic        wb_stb_i,     // wishbone strobe
   input  wire logic        wb_we_i,      // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,     // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,     // wishbone byte selects
   input  wire logic [31:0] wb_dat_i,     // wishbone write data
   output logic      [31:0] wb_dat_o,     // wishbone read data
   output logic             wb_ack_o,     // wishbone acknowledge
   output logic             wb_err_o,     // wishbone error, unmapped
   input  wire logic [2:0]  pin_i,        // pad levels, bit0 = port_bit4
   output logic      [2:0]  pin_o,        // pad output value
   output logic      [2:0]  pin_oe_o,     // pad driver enable
   output logic      [2:0]  pullup_o,     // pad pull-up enable
   input  wire logic        serial_clock_ch1_o_i,  // channel clock out
   input  wire logic        serial_clock_ch1_oe_i, // channel clock drive
   output logic             serial_clock_ch1_o,    // clock pin level in
   output logic             serial_in_ch1_o,       // serial in / scl in
   input  wire logic        i2c_clock_ch1_oe_i,    // scl drive (pulls low)
   input  wire logic        serial_out_ch1_i,      // serial out / sda out
   input  wire logic        serial_out_ch1_oe_i,   // data pin drive
   input  wire logic        stop_mode_i,  // chip is in stop mode
   output logic      [2:0]  wake_o        // interrupt/wake inputs
);
   localparam int W = gpf_pkg::PORT_WIDTH;
   localparam int L = gpf_pkg::PORT_LSB;

   // =====================================================================
   // state
   // =====================================================================
   typedef struct packed {
      logic [W-1:0] data;
      logic [W-1:0] oe;
      logic [W-1:0] fsel;
      logic [W-1:0] od;
      logic [W-1:0] pup;
      logic [W-1:0] ie;
      logic [1:0]   stop_ctrl;
      logic         ack;
      logic         err;
      logic [31:0]  rdata;
      logic [W-1:0] dout;
      logic [W-1:0] den;
      logic [W-1:0] pupq;
   } gpf_st_t;

   gpf_st_t st;
   gpf_st_t next_st;
   logic [W-1:0] pin_sync;
   logic [W-1:0] alt_o;
   logic [W-1:0] alt_oe;
   logic [W-1:0] pin_in;
   logic         drive_halt;

   // =====================================================================
   // pad input synchroniser
   // =====================================================================
   gpf_sync #(
      .WIDTH (W)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pin_i),
      .q_o   (pin_sync)
   );

   // =====================================================================
   // helpers
   // =====================================================================
   function automatic logic [W-1:0] field_of(input logic [31:0] v);
      field_of = v[L+W-1:L];
   endfunction

   function automatic logic [31:0] word_of(input logic [W-1:0] f);
      word_of = '0;
      word_of[L+W-1:L] = f;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      case (a & gpf_pkg::ADDR_MASK)
         gpf_pkg::OFS_PIN_DATA, gpf_pkg::OFS_OUTPUT_ENABLE, gpf_pkg::OFS_FUNCTION_SEL,
         gpf_pkg::OFS_OPEN_DRAIN, gpf_pkg::OFS_PULLUP, gpf_pkg::OFS_INPUT_ENABLE,
         gpf_pkg::OFS_STOP_CTRL: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // alternate sources: bit6 clock, bit5 scl, bit4 sda/serial out
   assign alt_o  = {serial_clock_ch1_o_i, 1'b0, serial_out_ch1_i};
   assign alt_oe = {serial_clock_ch1_oe_i, i2c_clock_ch1_oe_i, serial_out_ch1_oe_i};
   // stop with drive halt set silences pins
   assign drive_halt = stop_mode_i & st.stop_ctrl[gpf_pkg::STOP_DRV_POS];
   // input buffer gating
   assign pin_in = pin_sync & st.ie;

   // =====================================================================
   // next state
   // =====================================================================
   always_comb begin
      logic         req;
      logic [31:0]  wmask;
      logic [W-1:0] wf;
      logic [W-1:0] val;
      logic [W-1:0] en;
      req   = 1'b0;
      wmask = '0;
      wf    = '0;
      val   = '0;
      en    = '0;
      next_st = st;
      req   = wb_cyc_i & wb_stb_i & ~st.ack & ~st.err;
      next_st.ack = 1'b0;
      next_st.err = 1'b0;
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
      if (req) begin
         if (!mapped(wb_adr_i)) begin
            next_st.err = 1'b1;
         end else begin
            next_st.ack = 1'b1;
         end
         wf = field_of(wb_dat_i & wmask);
         if (wb_we_i && mapped(wb_adr_i) && wb_sel_i[0]) begin
            case (wb_adr_i & gpf_pkg::ADDR_MASK)
               gpf_pkg::OFS_PIN_DATA:      next_st.data = wf;
               gpf_pkg::OFS_OUTPUT_ENABLE: next_st.oe   = wf;
               gpf_pkg::OFS_FUNCTION_SEL:  next_st.fsel = wf;
               gpf_pkg::OFS_OPEN_DRAIN:    next_st.od   = wf;
               gpf_pkg::OFS_PULLUP:        next_st.pup  = wf;
               gpf_pkg::OFS_INPUT_ENABLE:  next_st.ie   = wf;
               // stop control lives in bits 5..4 so bits 3..0 stay unused
               gpf_pkg::OFS_STOP_CTRL:     next_st.stop_ctrl = wf[1:0];
               default:                    next_st.data = st.data;
            endcase
         end
         case (wb_adr_i & gpf_pkg::ADDR_MASK)
            gpf_pkg::OFS_PIN_DATA:      next_st.rdata = word_of(pin_in);
            gpf_pkg::OFS_OUTPUT_ENABLE: next_st.rdata = word_of(st.oe);
            gpf_pkg::OFS_FUNCTION_SEL:  next_st.rdata = word_of(st.fsel);
            gpf_pkg::OFS_OPEN_DRAIN:    next_st.rdata = word_of(st.od);
            gpf_pkg::OFS_PULLUP:        next_st.rdata = word_of(st.pup);
            gpf_pkg::OFS_INPUT_ENABLE:  next_st.rdata = word_of(st.ie);
            gpf_pkg::OFS_STOP_CTRL:     next_st.rdata = word_of({1'b0, st.stop_ctrl});
            default:                    next_st.rdata = '0;
         endcase
      end
      // per-pin mux: port or alternate, then push-pull or open drain
      for (int i = 0; i < W; i++) begin
         if (st.fsel[i]) begin
            val[i] = alt_o[i];
            en[i]  = alt_oe[i] & st.oe[i];
         end else begin
            val[i] = st.data[i];
            en[i]  = st.oe[i];
         end
         if (st.od[i]) begin
            en[i]  = en[i] & ~val[i];
            val[i] = 1'b0;
         end
      end
      if (drive_halt) begin
         en = '0;
      end
      next_st.dout = val;
      next_st.den  = en;
      next_st.pupq = st.pup;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // =====================================================================
   // outputs
   // =====================================================================
   assign wb_dat_o = st.rdata;
   assign wb_ack_o = st.ack;
   assign wb_err_o = st.err;
   assign pin_o    = st.dout;
   assign pin_oe_o = st.den;
   assign pullup_o = st.pupq;

   // peripheral sees pins only with alternate function and input enabled
   assign serial_clock_ch1_o = pin_in[2] & st.fsel[2];
   assign serial_in_ch1_o    = pin_in[1] & st.fsel[1];

   // wake: input enable alone outside stop; in stop also needs alt function
   // unused wake sources are the software's job to keep disabled
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (stop_mode_i) begin
            wake_o[i] = pin_sync[i] & st.ie[i] & st.fsel[i];
         end else begin
            wake_o[i] = pin_sync[i] & st.ie[i];
         end
      end
   end

   // =====================================================================
   // checks
   // =====================================================================
   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && mapped(wb_adr_i))
      |=> wb_ack_o)
      else $error("mapped access not acknowledged next cycle");

   a_reserved_err: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !mapped(wb_adr_i))
      |=> (wb_err_o && !wb_ack_o))
      else $error("reserved offset not refused");

   a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> (wb_dat_o[31:8] == 24'h0 && wb_dat_o[3:0] == 4'h0))
      else $error("unused read bits not zero");

   a_oe_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && !wb_err_o
       && wb_adr_i == gpf_pkg::OFS_OUTPUT_ENABLE && wb_dat_i[6:4] == 3'h0
       && !stop_mode_i) |=> ##1 (pin_oe_o == 3'h0))
      else $error("cleared output enable still drives");

   a_port_value: assert property (@(posedge clk_i) disable iff (rst_i)
      (st.fsel == 3'h0 && st.od == 3'h0 && $stable(st.data))
      |=> (pin_o == $past(st.data)))
      else $error("pin output differs from data register");

   a_od_no_high: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(st.od[0]) |-> !(pin_oe_o[0] && pin_o[0]))
      else $error("open drain pin driven high");

   a_pullup_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(st.pup) |=> (pullup_o == $past(st.pup)))
      else $error("pull-up output lags register");

   a_wake_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (st.ie == 3'h0) |-> (wake_o == 3'h0))
      else $error("wake passes with input disabled");

   a_reset_off: assert property (@(posedge clk_i)
      $past(rst_i) |-> (pin_oe_o == 3'h0 && pullup_o == 3'h0 && wake_o == 3'h0))
      else $error("pins not idle after reset");

   a_halt_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      (stop_mode_i && st.stop_ctrl[gpf_pkg::STOP_DRV_POS])
      |=> (pin_oe_o == 3'h0))
      else $error("pin still driven with drive halted in stop");

   a_wake_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      stop_mode_i |-> ((wake_o & ~st.fsel) == 3'h0))
      else $error("port-mode wake input passes in stop");

   a_wake_run: assert property (@(posedge clk_i) disable iff (rst_i)
      (!stop_mode_i && st.ie == 3'h7 && st.fsel == 3'h0)
      |-> (wake_o == pin_sync))
      else $error("wake blocked outside stop in port mode");

   a_serial_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (!st.fsel[2] && !st.fsel[1]) |-> (!serial_clock_ch1_o && !serial_in_ch1_o))
      else $error("channel sees pin in port mode");

   a_read_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && !wb_err_o
       && (wb_adr_i & gpf_pkg::ADDR_MASK) == gpf_pkg::OFS_PIN_DATA && st.ie == 3'h0)
      |=> (wb_dat_o == 32'h0))
      else $error("pin data read with input buffer blocked");

   a_port_enable: assert property (@(posedge clk_i) disable iff (rst_i)
      (!st.fsel[0] && !st.od[0] && !drive_halt) |=> (pin_oe_o[0] == $past(st.oe[0])))
      else $error("port output enable not applied");
endmodule // gpf_port

// [tb/gpf_pad_model.sv]
`timescale 1ns/1ps
// =====================================================================
// pad model: port driver, outside driver and pull-up per pin
// =====================================================================
module gpf_pad_model (
   input  wire logic       clk_i,      // system clock
   input  wire logic [2:0] port_val_i, // port output value
   input  wire logic [2:0] port_oe_i,  // port driver enable
   input  wire logic [2:0] port_pu_i,  // pull-up enable
   input  wire logic [2:0] ext_oe_i,   // outside driver enable
   input  wire logic [2:0] ext_i,      // outside driver value
   output logic      [2:0] pad_o       // resolved pad level
);
   // an undriven pad wanders, so a stale level never passes for a drive
   logic [2:0] flt = 3'h5;
   always_ff @(posedge clk_i) begin
      flt <= ~flt;
   end
   always_comb begin
      for (int b = 0; b < 3; b++) begin
         if (port_oe_i[b]) begin
            pad_o[b] = port_val_i[b];
         end else if (ext_oe_i[b]) begin
            pad_o[b] = ext_i[b];
         end else if (port_pu_i[b]) begin
            pad_o[b] = 1'b1;
         end else begin
            pad_o[b] = flt[b];
         end
      end
   end
endmodule // gpf_pad_model

// [tb/three_bit_gpio_port_tb.sv]
`timescale 1ns/1ps
module three_bit_gpio_port_tb;
   logic        clk_i, rst_i, cyc, stb, we, ack, err;
   logic        sck_o, sck_oe, scl_oe, so, so_oe, stop, sck_in, si_in;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [2:0]  pin_i, pin_o, pin_oe_o, pullup_o, ext_oe, ext, wake;
   logic        e;
   int          failures, tests_run;
   logic [7:0]  ofs [6] = '{gpf_pkg::OFS_PIN_DATA, gpf_pkg::OFS_OUTPUT_ENABLE,
      gpf_pkg::OFS_FUNCTION_SEL, gpf_pkg::OFS_OPEN_DRAIN, gpf_pkg::OFS_PULLUP,
      gpf_pkg::OFS_INPUT_ENABLE};

   gpf_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o),
      .serial_clock_ch1_o_i(sck_o), .serial_clock_ch1_oe_i(sck_oe),
      .serial_clock_ch1_o(sck_in), .serial_in_ch1_o(si_in),
      .i2c_clock_ch1_oe_i(scl_oe), .serial_out_ch1_i(so),
      .serial_out_ch1_oe_i(so_oe), .stop_mode_i(stop), .wake_o(wake));
   gpf_pad_model pads (.clk_i(clk_i), .port_val_i(pin_o), .port_oe_i(pin_oe_o),
      .port_pu_i(pullup_o), .ext_oe_i(ext_oe), .ext_i(ext), .pad_o(pin_i));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // =====================================================================
   // bus and check tasks
   // =====================================================================
   task automatic report_and_stop;
      if (failures == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // classic cycle; the request stands until ack or err is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
      end
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(q, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // =====================================================================
   // tests
   // =====================================================================
   initial begin
      {cyc, stb, we, sck_o, sck_oe, scl_oe, so, so_oe, stop} = 9'h0;
      {adr, sel, wdat, ext_oe, ext, failures, tests_run} = '0;
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++) rd(ofs[i], 32'h0);
      chk(32'({pin_oe_o, pullup_o, sck_in, si_in, wake}), 32'h0);
      for (int i = 1; i < 6; i++) begin
         wr(ofs[i], 32'hFFFFFF50);
         rd(ofs[i], 32'h50);
         wr(ofs[i], 32'h0);
      end
      bus(1'b1, gpf_pkg::OFS_PULLUP, 32'h70, 4'hE);
      rd(gpf_pkg::OFS_PULLUP, 32'h0);
      // reserved offset read must be refused with err and return zero
      bus(1'b0, gpf_pkg::OFS_RESERVED, 32'h0, 4'hF);
      chk(q, 32'h0);
      chk(32'(e), 32'h1);
      wr(gpf_pkg::OFS_OUTPUT_ENABLE, 32'h70);
      wr(gpf_pkg::OFS_PIN_DATA, 32'h50);
      settle(2);
      chk(32'(pin_oe_o), 32'h7);
      chk(32'(pin_o), 32'h5);
      rd(gpf_pkg::OFS_PIN_DATA, 32'h0);
      wr(gpf_pkg::OFS_INPUT_ENABLE, 32'h70);
      settle(8);
      rd(gpf_pkg::OFS_PIN_DATA, 32'h50);
      chk(32'(wake), 32'h5);
      // bits act alone: only bit 6 drives, the rest come from outside
      wr(gpf_pkg::OFS_OUTPUT_ENABLE, 32'h40);
      ext_oe <= 3'h3;
      ext <= 3'h2;
      settle(8);
      chk(32'(pin_oe_o), 32'h4);
      rd(gpf_pkg::OFS_PIN_DATA, 32'h60);
      chk(32'(wake), 32'h6);
      ext_oe <= 3'h0;
      wr(gpf_pkg::OFS_OUTPUT_ENABLE, 32'h70);
      wr(gpf_pkg::OFS_OPEN_DRAIN, 32'h70);
      wr(gpf_pkg::OFS_PULLUP, 32'h70);
      settle(8);
      chk(32'(pin_oe_o), 32'h2);
      chk(32'(pullup_o), 32'h7);
      rd(gpf_pkg::OFS_PIN_DATA, 32'h50);
      wr(gpf_pkg::OFS_OPEN_DRAIN, 32'h0);
      wr(gpf_pkg::OFS_PULLUP, 32'h0);
      wr(gpf_pkg::OFS_INPUT_ENABLE, 32'h0);
      settle(4);
      chk(32'(wake), 32'h0);
      {sck_o, sck_oe, scl_oe, so, so_oe} <= 5'h1D;
      wr(gpf_pkg::OFS_FUNCTION_SEL, 32'h70);
      settle(2);
      chk(32'(pin_oe_o), 32'h7);
      chk(32'(pin_o), 32'h4);
      wr(gpf_pkg::OFS_INPUT_ENABLE, 32'h70);
      settle(8);
      chk(32'({sck_in, si_in}), 32'h2);
      // stop with drive halted: the wake path must still see the pins
      {sck_oe, scl_oe, so_oe} <= 3'h0;
      ext_oe <= 3'h7;
      ext <= 3'h5;
      stop <= 1'b1;
      wr(gpf_pkg::OFS_STOP_CTRL, 32'h10);
      settle(8);
      chk(32'(wake), 32'h5);
      // port mode in stop: wake closed, drive still halted
      wr(gpf_pkg::OFS_FUNCTION_SEL, 32'h0);
      settle(2);
      chk(32'(wake), 32'h0);
      chk(32'(pin_oe_o), 32'h0);
      rd(gpf_pkg::OFS_PIN_DATA, 32'h50);
      stop <= 1'b0;
      settle(4);
      chk(32'(wake), 32'h5);
      chk(32'(pin_oe_o), 32'h7);
      report_and_stop();
   end
   initial begin
      #(8 * 5000);
      failures++;
      report_and_stop();
   end
endmodule // three_bit_gpio_port_tb
